/* File: src/csr_alu_flags.v */
// Flag computation for add, subtract and logic results
`timescale 1ns/1ps
module csr_alu_flags (
  input wire [2:0] op, // Operation code
  input wire [7:0] opa, // First operand
  input wire [7:0] opb, // Second operand
  output reg [7:0] result, // Result byte
  output reg zero, // Result is zero
  output reg half, // Carry from bit 3
  output reg carry, // Carry from bit 7
  output reg affects // Op updates arithmetic flags
);
`include "csr_regs.vh"
  reg [8:0] sum;
  reg [4:0] low;
  always @* begin
    sum = 9'h000;
    low = 5'h00;
    result = opb;
    half = 1'b0;
    carry = 1'b0;
    affects = 1'b0;
    case (op)
      `CSR_OP_ADD: begin
        sum = {1'b0, opa} + {1'b0, opb};
        low = {1'b0, opa[3:0]} + {1'b0, opb[3:0]};
        result = sum[7:0];
        half = low[4];
        carry = sum[8];
        affects = 1'b1;
      end
      `CSR_OP_SUB: begin
        sum = {1'b0, opa} + {1'b0, ~opb} + 9'h001;
        low = {1'b0, opa[3:0]} + {1'b0, ~opb[3:0]} + 5'h01;
        result = sum[7:0];
        half = low[4];
        carry = sum[8];
        affects = 1'b1;
      end
      `CSR_OP_LOGIC: begin
        result = opa & opb;
        affects = 1'b1;
      end
      `CSR_OP_CLEAR: begin
        result = 8'h00;
        affects = 1'b1;
      end
      default: begin
        result = opb;
      end
    endcase
    zero = (result == 8'h00);
  end
endmodule // csr_alu_flags

/* File: src/csr_bank_decode.v */
// Bank address formation and status alias detection
`timescale 1ns/1ps
module csr_bank_decode (
  input wire [1:0] direct_bank, // Direct bank bits
  input wire indirect_bank_bit, // Indirect bank bit
  input wire [6:0] dir_addr, // Direct offset in bank
  input wire [7:0] ind_addr, // Indirect pointer
  input wire use_indirect, // Select indirect path
  output reg [8:0] full_addr, // Full data address
  output reg hit_status // Address is the status alias
);
`include "csr_regs.vh"
  always @* begin
    if (use_indirect)
      full_addr = {indirect_bank_bit, ind_addr};
    else
      full_addr = {direct_bank, dir_addr};
    hit_status = (full_addr == `CSR_ADDR_BANK0) ||
      (full_addr == `CSR_ADDR_BANK1) ||
      (full_addr == `CSR_ADDR_BANK2) ||
      (full_addr == `CSR_ADDR_BANK3);
  end
endmodule // csr_bank_decode

/* File: src/csr_core_status.v */
// Core status register with APB access and core instruction port
`timescale 1ns/1ps
module csr_core_status (
  input wire pclk, // Core clock
  input wire presetn, // Async reset, active low
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error
  input wire exec_valid, // Core instruction strobe
  input wire [2:0] exec_op, // Core operation code
  input wire [7:0] exec_opa, // Core operand a
  input wire [7:0] exec_opb, // Core operand b / write data
  input wire [6:0] exec_dir_addr, // Direct offset
  input wire [7:0] exec_ind_addr, // Indirect pointer
  input wire exec_indirect, // Use indirect addressing
  input wire watchdog_refresh_op, // Refresh executed
  input wire sleep_op, // Sleep executed
  input wire watchdog_timeout, // Watchdog timed out
  output reg [7:0] status_out, // Current status value
  output reg [8:0] exec_addr_out, // Resolved data address
  output reg exec_result_zero // Zero of last result
);
`include "csr_regs.vh"
  reg [7:0] stat_ff;
  reg [7:0] nxt_stat;
  reg [8:0] ev_addr_ff;
  reg [8:0] nxt_ev_addr;
  reg zres_ff;
  reg nxt_zres;
  reg [31:0] nxt_prdata;
  reg nxt_pslverr;
  wire [7:0] alu_res;
  wire alu_z;
  wire alu_hc;
  wire alu_c;
  wire alu_aff;
  wire [8:0] full_addr;
  wire hit_status;
  wire apb_acc;
  wire apb_wr;

  assign apb_acc = psel & penable & pready;
  assign apb_wr = apb_acc & pwrite;

  // Status offset decode, shared by the write and read paths
  function is_status_addr;
    input [11:0] addr;
    begin
      is_status_addr = (addr == `CSR_APB_STATUS);
    end
  endfunction

  csr_alu_flags u_alu (
    .op(exec_op),
    .opa(exec_opa),
    .opb(exec_opb),
    .result(alu_res),
    .zero(alu_z),
    .half(alu_hc),
    .carry(alu_c),
    .affects(alu_aff)
  );

  csr_bank_decode u_dec (
    .direct_bank(stat_ff[`CSR_BIT_RPHI:`CSR_BIT_RPLO]),
    .indirect_bank_bit(stat_ff[`CSR_BIT_INDB]),
    .dir_addr(exec_dir_addr),
    .ind_addr(exec_ind_addr),
    .use_indirect(exec_indirect),
    .full_addr(full_addr),
    .hit_status(hit_status)
  );

  always @* begin
    nxt_stat = stat_ff;
    nxt_ev_addr = ev_addr_ff;
    nxt_zres = zres_ff;
    if (exec_valid) begin
      nxt_ev_addr = full_addr;
      nxt_zres = alu_z;
      if (hit_status) begin
        // write low bits only if op has no flags
        if (!alu_aff) begin
          nxt_stat[`CSR_BIT_ZERO] = alu_res[`CSR_BIT_ZERO];
          nxt_stat[`CSR_BIT_HALF] = alu_res[`CSR_BIT_HALF];
          nxt_stat[`CSR_BIT_CARRY] = alu_res[`CSR_BIT_CARRY];
        end
        nxt_stat[`CSR_BIT_INDB] = alu_res[`CSR_BIT_INDB];
        nxt_stat[`CSR_BIT_RPHI] = alu_res[`CSR_BIT_RPHI];
        nxt_stat[`CSR_BIT_RPLO] = alu_res[`CSR_BIT_RPLO];
      end
      if (alu_aff) begin
        nxt_stat[`CSR_BIT_ZERO] = alu_z;
        if (exec_op == `CSR_OP_ADD || exec_op == `CSR_OP_SUB) begin
          nxt_stat[`CSR_BIT_HALF] = alu_hc;
          nxt_stat[`CSR_BIT_CARRY] = alu_c;
        end
      end
      if (hit_status && exec_op == `CSR_OP_CLEAR) begin
        nxt_stat[`CSR_BIT_INDB] = 1'b0;
        nxt_stat[`CSR_BIT_RPHI] = 1'b0;
        nxt_stat[`CSR_BIT_RPLO] = 1'b0;
        nxt_stat[`CSR_BIT_ZERO] = 1'b1;
      end
    end
    // APB write reaches bank bits and arithmetic flags only
    if (apb_wr && is_status_addr(paddr)) begin
      nxt_stat[`CSR_BIT_INDB] = pwdata[`CSR_BIT_INDB];
      nxt_stat[`CSR_BIT_RPHI] = pwdata[`CSR_BIT_RPHI];
      nxt_stat[`CSR_BIT_RPLO] = pwdata[`CSR_BIT_RPLO];
      nxt_stat[`CSR_BIT_ZERO] = pwdata[`CSR_BIT_ZERO];
      nxt_stat[`CSR_BIT_HALF] = pwdata[`CSR_BIT_HALF];
      nxt_stat[`CSR_BIT_CARRY] = pwdata[`CSR_BIT_CARRY];
    end
    if (watchdog_refresh_op) begin
      nxt_stat[`CSR_BIT_SLEEP] = 1'b1;
      nxt_stat[`CSR_BIT_WDOG] = 1'b1;
    end else if (sleep_op) begin
      nxt_stat[`CSR_BIT_SLEEP] = 1'b0;
      nxt_stat[`CSR_BIT_WDOG] = 1'b1;
    end
    // Timeout wins: a lost expiry would hide a real fault
    if (watchdog_timeout)
      nxt_stat[`CSR_BIT_WDOG] = 1'b0;
  end

  always @* begin
    nxt_prdata = 32'h00000000;
    nxt_pslverr = 1'b0;
    if (is_status_addr(paddr))
      nxt_prdata = {24'h000000, stat_ff};
    else if (paddr == `CSR_APB_EVENT)
      nxt_prdata = {22'h000000, zres_ff, ev_addr_ff};
    else if (paddr == `CSR_APB_BANK)
      nxt_prdata = {29'h00000000, stat_ff[`CSR_BIT_INDB],
        stat_ff[`CSR_BIT_RPHI:`CSR_BIT_RPLO]};
    else
      nxt_pslverr = 1'b1;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // reset values, arithmetic flags held at zero
      stat_ff <= {`CSR_RST_BANK, `CSR_RST_CAUSE, `CSR_RST_ARITH};
      ev_addr_ff <= 9'h000;
      zres_ff <= 1'b0;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      // Mirror shows the reset status, not zero
      status_out <= {`CSR_RST_BANK, `CSR_RST_CAUSE, `CSR_RST_ARITH};
      exec_addr_out <= 9'h000;
      exec_result_zero <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
      ev_addr_ff <= nxt_ev_addr;
      zres_ff <= nxt_zres;
      // One wait state: ready is high in the second access cycle
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready) begin
        prdata <= pwrite ? 32'h00000000 : nxt_prdata;
        pslverr <= nxt_pslverr;
      end else begin
        pslverr <= 1'b0;
      end
      status_out <= nxt_stat;
      exec_addr_out <= nxt_ev_addr;
      exec_result_zero <= nxt_zres;
    end
  end
endmodule // csr_core_status

/* File: src/csr_regs.vh */
// Core status register offsets, field positions and reset values
`ifndef CSR_REGS_VH
`define CSR_REGS_VH
`define CSR_ADDR_BANK0 9'h003
`define CSR_ADDR_BANK1 9'h083
`define CSR_ADDR_BANK2 9'h103
`define CSR_ADDR_BANK3 9'h183
`define CSR_APB_STATUS 12'h00C
`define CSR_APB_EVENT 12'h010
`define CSR_APB_BANK 12'h014
`define CSR_BIT_CARRY 0
`define CSR_BIT_HALF 1
`define CSR_BIT_ZERO 2
`define CSR_BIT_SLEEP 3
`define CSR_BIT_WDOG 4
`define CSR_BIT_RPLO 5
`define CSR_BIT_RPHI 6
`define CSR_BIT_INDB 7
`define CSR_OP_WRITE 3'h0
`define CSR_OP_ADD 3'h1
`define CSR_OP_SUB 3'h2
`define CSR_OP_LOGIC 3'h3
`define CSR_OP_CLEAR 3'h4
`define CSR_OP_NOFLAG 3'h5
`define CSR_RST_BANK 3'h0
`define CSR_RST_CAUSE 2'h3
`define CSR_RST_ARITH 3'h0
`endif

/* File: tb/csr_core_status_sva.sv */
// Port assertions for the core status register
`timescale 1ns/1ps
`include "csr_regs.vh"
module csr_core_status_sva (
  input wire pclk, // Clock
  input wire presetn, // Reset
  input wire psel, // Select
  input wire penable, // Enable
  input wire pwrite, // Write
  input wire [11:0] paddr, // Address
  input wire pready, // Ready
  input wire pslverr, // Error
  input wire exec_valid, // Core strobe
  input wire [2:0] exec_op, // Core op
  input wire [6:0] exec_dir_addr, // Direct offset
  input wire exec_indirect, // Indirect mode
  input wire watchdog_refresh_op, // Refresh
  input wire sleep_op, // Sleep
  input wire watchdog_timeout, // Timeout
  input wire [7:0] status_out, // Status
  input wire [8:0] exec_addr_out // Address out
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // APB write wins over the core, so core checks skip it
  wire apb_w = psel & penable & pwrite;
  wire st_dir = exec_valid & !exec_indirect & (exec_dir_addr == 7'h03);
  wire no_ev = !watchdog_refresh_op & !sleep_op & !watchdog_timeout;
  wire bad_a = !(paddr inside {12'h00C, 12'h010, 12'h014});
  sequence s_setup;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence s_clr;
    st_dir && exec_op == `CSR_OP_CLEAR && !apb_w;
  endsequence
  property p_ready;
    s_setup |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready) else $error("ready timing");
  property p_err;
    psel && penable && pready && bad_a |-> pslverr;
  endproperty
  a_err: assert property (p_err) else $error("no slave error");
  property p_cause;
    no_ev |=> $stable(status_out[4:3]);
  endproperty
  a_cause: assert property (p_cause) else $error("cause bits moved");
  property p_sleep;
    sleep_op && !watchdog_refresh_op && !watchdog_timeout
      |=> status_out[4:3] == 2'h2;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep flags");
  property p_tmo;
    watchdog_timeout |=> !status_out[4];
  endproperty
  a_tmo: assert property (p_tmo) else $error("timeout flag");
  property p_refresh;
    watchdog_refresh_op && !watchdog_timeout |=> status_out[4:3] == 2'h3;
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh");
  property p_clear;
    s_clr |=> status_out[7:5] == 3'h0 && status_out[2]
      && status_out[1:0] == $past(status_out[1:0]);
  endproperty
  a_clear: assert property (p_clear) else $error("clear op");
  property p_addr;
    exec_valid && !exec_indirect
      |=> exec_addr_out == {$past(status_out[6:5]), $past(exec_dir_addr)};
  endproperty
  a_addr: assert property (p_addr) else $error("direct address");
  property p_keep;
    exec_valid && exec_op == `CSR_OP_NOFLAG && !exec_indirect && !st_dir
      && !apb_w |=> $stable(status_out[2:0]);
  endproperty
  a_keep: assert property (p_keep) else $error("flags moved");
endmodule // csr_core_status_sva
bind csr_core_status csr_core_status_sva u_csr_core_status_sva (.pclk,
  .presetn, .psel, .penable, .pwrite, .paddr, .pready, .pslverr,
  .exec_valid, .exec_op, .exec_dir_addr, .exec_indirect,
  .watchdog_refresh_op, .sleep_op, .watchdog_timeout, .status_out,
  .exec_addr_out);

/* File: tb/tb.sv */
// Self-checking bench for the core status register
`timescale 1ns/1ps
`include "csr_regs.vh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin failures++; \
  $display("[ERR] %0t got %0h", $time, a); end end
module tb;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, rd;
  reg exec_valid = 0, exec_indirect = 0, watchdog_refresh_op = 0, er;
  reg sleep_op = 0, watchdog_timeout = 0;
  reg [2:0] exec_op = 0;
  reg [7:0] exec_opa = 0, exec_opb = 0, exec_ind_addr = 0;
  reg [6:0] exec_dir_addr = 0;
  wire [31:0] prdata;
  wire pready, pslverr, exec_result_zero;
  wire [7:0] status_out;
  wire [8:0] exec_addr_out;
  integer failures = 0, n_tests = 0, b;
  // Flag cases: add, and, sub, add; lowest entry first
  localparam [11:0] OPS = {3'h1, 3'h2, 3'h3, 3'h1};
  localparam [31:0] OPA = {8'h08, 8'h05, 8'hF0, 8'h08};
  localparam [31:0] OPB = {8'h08, 8'h05, 8'h0F, 8'h08};
  localparam [11:0] FLG = {3'h2, 3'h7, 3'h6, 3'h2};
  localparam [11:0] EVM = {3'h5, 3'h1, 3'h4, 3'h2};
  localparam [7:0] CZ = {2'h1, 2'h3, 2'h0, 2'h2};
  csr_core_status u_csr_core_status (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .exec_valid,
    .exec_op, .exec_opa, .exec_opb, .exec_dir_addr, .exec_ind_addr,
    .exec_indirect, .watchdog_refresh_op, .sleep_op, .watchdog_timeout,
    .status_out, .exec_addr_out, .exec_result_zero);
  initial forever #20 pclk = ~pclk;
  task test_done;
    begin
      $display("checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      k = 0;
      do begin
        @(posedge pclk);
        k = k + 1;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      @(negedge pclk);
      if (k == 50) begin
        failures++;
        test_done;
      end
    end
  endtask
  task ex(input [2:0] o, input [7:0] a, input [7:0] v, input [7:0] ad,
    input i);
    begin
      @(posedge pclk);
      exec_valid <= 1;
      exec_op <= o;
      exec_opa <= a;
      exec_opb <= v;
      exec_dir_addr <= ad[6:0];
      exec_ind_addr <= ad;
      exec_indirect <= i;
      @(posedge pclk);
      exec_valid <= 0;
      @(negedge pclk);
    end
  endtask
  task ev(input [2:0] m);
    begin
      @(posedge pclk);
      {watchdog_timeout, sleep_op, watchdog_refresh_op} <= m;
      @(posedge pclk);
      {watchdog_timeout, sleep_op, watchdog_refresh_op} <= 3'h0;
      @(negedge pclk);
    end
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(negedge pclk);
    `CHK(status_out[7:3], 5'h03)
    apb(0, `CSR_APB_STATUS, 0);
    `CHK(rd[7:3], 5'h03)
    apb(0, 12'h100, 0);
    `CHK(er, 1'b1)
    $display("reset test done");
    for (b = 0; b < 4; b = b + 1) begin
      apb(1, `CSR_APB_STATUS, b << 5);
      `CHK(status_out, {1'b0, b[1:0], 5'h18})
      ex(5, 0, {1'b0, b[1:0], 5'h07}, 8'h03, 0);
      `CHK(status_out, {1'b0, b[1:0], 5'h1F})
      `CHK(exec_addr_out, {b[1:0], 7'h03})
    end
    ex(0, 0, 8'hE0, 8'h03, 0);
    `CHK(status_out, 8'hF8)
    apb(0, `CSR_APB_BANK, 0);
    `CHK(rd, 32'h00000007)
    ex(0, 0, 8'h00, 8'h03, 1);
    `CHK(exec_addr_out, 9'h103)
    `CHK(status_out, 8'h18)
    $display("bank test done");
    for (b = 0; b < 4; b = b + 1) begin
      ex(OPS[3*b +: 3], OPA[8*b +: 8], OPB[8*b +: 8], 8'h20, 0);
      `CHK(status_out, {5'h03, FLG[3*b +: 3]})
    end
    ex(5, 0, 8'hFF, 8'h20, 0);
    `CHK(status_out[2:0], 3'h2)
    ex(0, 0, 8'h60, 8'h03, 0);
    ex(1, 8'hFF, 8'h01, 8'h03, 0);
    `CHK(status_out, 8'h1F)
    `CHK(exec_result_zero, 1'b1)
    apb(0, `CSR_APB_EVENT, 0);
    `CHK(rd, 32'h00000383)
    ex(0, 0, 8'hE3, 8'h03, 0);
    ex(4, 0, 0, 8'h03, 0);
    `CHK(status_out, 8'h1F)
    $display("flag test done");
    for (b = 0; b < 4; b = b + 1) begin
      ev(EVM[3*b +: 3]);
      `CHK(status_out[4:3], CZ[2*b +: 2])
    end
    apb(1, `CSR_APB_STATUS, 32'h10);
    apb(0, `CSR_APB_STATUS, 0);
    `CHK(rd[7:0], 8'h08)
    $display("event test done");
    @(posedge pclk);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(negedge pclk);
    `CHK(status_out, 8'h18)
    `CHK(exec_addr_out, 9'h000)
    $display("second reset test done");
    test_done;
  end
endmodule // tb
